//--- hw/dpll_clock_recovery.sv
// Digital phase-locked loop recovering receive and transmit clocks from serial data
`include "dpll_consts.svh"

module dpll_clock_recovery (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       rxData,
  input  wire logic [7:0] ctrlByte,
  input  wire logic       ctrlWrite,
  output logic            rxClk,
  output logic            txClk,
  output logic            srcBrg,
  output logic            fmMode,
  output logic            enabled,
  output logic            searching,
  output logic            oneMissing,
  output logic            twoMissing
);
  import dpll_pkg::*;

  //--------------------------------------------------------------
  // Decode helpers
  //--------------------------------------------------------------
  function automatic logic rxLevel(input logic [4:0] c, input logic fm);
    logic [4:0] p;
    p = 5'(c + `DPLL_FM_RX_PHASE);
    rxLevel = fm ? p[3] : c[4];
  endfunction

  function automatic logic txLevel(input logic [4:0] c, input logic fm);
    txLevel = fm ? c[3] : c[4];
  endfunction

  function automatic logic inWindow(input logic [4:0] c);
    inWindow = (c >= `DPLL_FM_WIN_LO) && (c <= `DPLL_FM_WIN_HI);
  endfunction

  // R8 R9 R15 R16 edge position classes
  function automatic adj_t classify(input logic [4:0] c, input logic fm);
    adj_t a;
    a = ADJ_NONE;
    if (c == `DPLL_NRZI_OK_LO || c == `DPLL_NRZI_OK_HI) begin
      a = ADJ_NONE;
    end else if (!fm) begin
      a = (c > `DPLL_NRZI_OK_HI) ? ADJ_LONG : ADJ_SHORT;
    end else if (c > `DPLL_NRZI_OK_HI && c <= `DPLL_FM_WIN_HI) begin
      a = ADJ_LONG;
    end else if (c >= `DPLL_FM_WIN_LO && c < `DPLL_NRZI_OK_LO) begin
      a = ADJ_SHORT;
    end else begin
      a = ADJ_IGNORE;
    end
    classify = a;
  endfunction

  //--------------------------------------------------------------
  // Reset value and state
  //--------------------------------------------------------------
  localparam dpll_state_t RESET_STATE = '{
    st:       ST_OFF,
    cnt:      `DPLL_SEARCH_CNT,
    adj:      ADJ_NONE,
    seen:     1'b0,
    missPrev: 1'b0,
    goHunt:   1'b0,
    fm:       1'b0,
    srcBrg:   1'b0,
    oneMiss:  1'b0,
    twoMiss:  1'b0,
    rxClk:    1'b1,
    txClk:    1'b1
  };

  dpll_state_t s_r;
  dpll_state_t s_nxt;
  logic [2:0]  cmd;
  logic        cmdHunt;
  logic        cmdClr;
  logic        cmdOff;
  logic        cmdHit;
  logic        edgePulse;
  logic        missed;
  adj_t        cls;

  //--------------------------------------------------------------
  // Command decode
  //--------------------------------------------------------------
  // R24 command field in bits 7 to 5
  assign cmd     = ctrlByte[`DPLL_CMD_MSB:`DPLL_CMD_LSB];
  assign cmdHit  = ctrlWrite && (cmd != `DPLL_CMD_NULL);
  assign cmdHunt = ctrlWrite && (cmd == `DPLL_CMD_HUNT);
  assign cmdClr  = ctrlWrite && (cmd == `DPLL_CMD_CLRMISS);
  assign cmdOff  = ctrlWrite && (cmd == `DPLL_CMD_DISABLE);

  //--------------------------------------------------------------
  // Edge detector
  //--------------------------------------------------------------
  dpll_edge_detect u_edge (
    .mclk      (mclk),
    .rst       (rst),
    .rxData    (rxData),
    .armed     (s_r.st != ST_OFF),
    .edgePulse (edgePulse)
  );

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    s_nxt  = s_r;
    missed = 1'b0;
    cls    = classify(s_r.cnt, s_r.fm);
    // R21 clear command, hardware set below wins
    if (cmdClr) begin
      s_nxt.oneMiss = 1'b0;
      s_nxt.twoMiss = 1'b0;
    end
    unique case (s_r.st)
      ST_OFF: begin
        s_nxt.cnt = `DPLL_SEARCH_CNT;
      end
      ST_HUNT: begin
        // R3 first edge taken as a cell boundary
        if (edgePulse) begin
          s_nxt.st  = ST_RUN;
          s_nxt.cnt = 5'(s_r.cnt + 5'h01);
          s_nxt.seen = s_r.fm;
        end else begin
          s_nxt.cnt = `DPLL_SEARCH_CNT;
        end
      end
      ST_RUN: begin
        // R11 lengthening applied at count 5, shortening at count 4
        if (s_r.adj == ADJ_LONG && s_r.cnt == `DPLL_ADJ_CNT) begin
          s_nxt.adj = ADJ_NONE;
        end else if (s_r.adj == ADJ_SHORT && s_r.cnt == `DPLL_PRE_ADJ_CNT) begin
          s_nxt.cnt = 5'(s_r.cnt + 5'h02);
          s_nxt.adj = ADJ_NONE;
        end else begin
          // R4 R14 free run over 32 counts
          s_nxt.cnt = 5'(s_r.cnt + 5'h01);
        end
        // R5 R10 only edges set corrections
        if (edgePulse && cls != ADJ_IGNORE) begin
          s_nxt.adj = cls;
        end
        if (s_r.fm && edgePulse && inWindow(s_r.cnt)) begin
          s_nxt.seen = 1'b1;
        end
        // R19 boundary window closes at count 19
        if (s_r.fm && s_r.cnt == `DPLL_FM_WIN_HI) begin
          missed         = !(s_r.seen || (edgePulse && inWindow(s_r.cnt)));
          s_nxt.seen     = 1'b0;
          s_nxt.missPrev = missed;
          if (missed) begin
            s_nxt.oneMiss = 1'b1;
          end
          // R20 second missed cycle
          if (missed && s_r.missPrev) begin
            s_nxt.twoMiss = 1'b1;
            s_nxt.goHunt  = 1'b1;
          end
        end
        // R20 search entered at count 2
        if (s_r.goHunt && s_r.cnt == `DPLL_DECIDE_CNT) begin
          s_nxt.st       = ST_HUNT;
          s_nxt.cnt      = `DPLL_SEARCH_CNT;
          s_nxt.adj      = ADJ_NONE;
          s_nxt.seen     = 1'b0;
          s_nxt.missPrev = 1'b0;
          s_nxt.goHunt   = 1'b0;
        end
      end
    endcase
    // R1 R2 begin hunt enables or restarts search
    if (cmdHunt || cmdOff) begin
      s_nxt.st       = cmdHunt ? ST_HUNT : ST_OFF;
      s_nxt.cnt      = `DPLL_SEARCH_CNT;
      s_nxt.adj      = ADJ_NONE;
      s_nxt.seen     = 1'b0;
      s_nxt.missPrev = 1'b0;
      s_nxt.goHunt   = 1'b0;
      s_nxt.oneMiss  = 1'b0;
      s_nxt.twoMiss  = 1'b0;
    end
    // R18 mode and source selection
    if (ctrlWrite) begin
      unique case (cmd)
        `DPLL_CMD_FM:      s_nxt.fm = 1'b1;
        `DPLL_CMD_NRZI:    s_nxt.fm = 1'b0;
        `DPLL_CMD_SRC_BRG: s_nxt.srcBrg = 1'b1;
        `DPLL_CMD_SRC_PIN: s_nxt.srcBrg = 1'b0;
        default: ;
      endcase
    end
    // R22 flags held clear in NRZI or disabled
    if (!s_nxt.fm || s_nxt.st == ST_OFF) begin
      s_nxt.oneMiss = 1'b0;
      s_nxt.twoMiss = 1'b0;
    end
    // R7 R12 R13 R17 output decoders
    s_nxt.rxClk = rxLevel(s_nxt.cnt, s_nxt.fm);
    s_nxt.txClk = txLevel(s_nxt.cnt, s_nxt.fm);
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  // R23 reset disables, pin source, NRZI
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rxClk      = s_r.rxClk;
  assign txClk      = s_r.txClk;
  assign srcBrg     = s_r.srcBrg;
  assign fmMode     = s_r.fm;
  assign enabled    = (s_r.st != ST_OFF);
  assign searching  = (s_r.st != ST_RUN);
  assign oneMissing = s_r.oneMiss;
  assign twoMissing = s_r.twoMiss;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_off_frozen;
    s_r.st == ST_OFF && !cmdHit |=> s_r.st == ST_OFF && s_r.cnt == `DPLL_SEARCH_CNT;
  endproperty
  a_off_frozen: assert property (p_off_frozen) else $error("counter moved while disabled"); // R1

  property p_hunt_restart;
    s_r.st == ST_RUN && cmdHunt |=> s_r.st == ST_HUNT && s_r.cnt == `DPLL_SEARCH_CNT;
  endproperty
  a_hunt_restart: assert property (p_hunt_restart) else $error("hunt did not restart search"); // R2

  property p_hunt_lock;
    s_r.st == ST_HUNT && edgePulse && !cmdHit |=> s_r.st == ST_RUN && s_r.cnt == 5'h11;
  endproperty
  a_hunt_lock: assert property (p_hunt_lock) else $error("first edge did not start counting"); // R3

  property p_hunt_wait;
    s_r.st == ST_HUNT && !edgePulse && !cmdHit |=> s_r.st == ST_HUNT;
  endproperty
  a_hunt_wait: assert property (p_hunt_wait) else $error("search left without an edge"); // R3

  property p_free_run;
    s_r.st == ST_RUN && s_r.adj == ADJ_NONE && s_r.cnt == `DPLL_ADJ_CNT && !cmdHit && !s_r.goHunt
      |=> s_r.cnt == 5'h06;
  endproperty
  a_free_run: assert property (p_free_run) else $error("count 5 altered without correction"); // R4

  property p_lengthen;
    s_r.st == ST_RUN && s_r.adj == ADJ_LONG && s_r.cnt == `DPLL_ADJ_CNT && !cmdHit
      |=> s_r.cnt == `DPLL_ADJ_CNT ##1 s_r.cnt == 5'h06;
  endproperty
  a_lengthen: assert property (p_lengthen) else $error("count 5 not doubled"); // R11

  property p_shorten;
    s_r.st == ST_RUN && s_r.adj == ADJ_SHORT && s_r.cnt == `DPLL_PRE_ADJ_CNT && !cmdHit
      |=> s_r.cnt == 5'h06;
  endproperty
  a_shorten: assert property (p_shorten) else $error("count 5 not deleted"); // R11

  property p_nrzi_class;
    s_r.st == ST_RUN && !s_r.fm && edgePulse && !cmdHit && s_r.cnt != `DPLL_ADJ_CNT
      |=> s_r.adj == (($past(s_r.cnt) == 5'h0f || $past(s_r.cnt) == 5'h10) ? ADJ_NONE :
                      ($past(s_r.cnt) > 5'h10) ? ADJ_LONG : ADJ_SHORT);
  endproperty
  a_nrzi_class: assert property (p_nrzi_class) else $error("wrong NRZI correction"); // R9

  property p_fm_ignore;
    s_r.st == ST_RUN && s_r.fm && edgePulse && !cmdHit && (s_r.cnt > 5'h13 || s_r.cnt < 5'h04)
      |=> s_r.adj == $past(s_r.adj);
  endproperty
  a_fm_ignore: assert property (p_fm_ignore) else $error("FM data edge changed count"); // R16

  property p_fm_long;
    s_r.st == ST_RUN && s_r.fm && edgePulse && !cmdHit && s_r.cnt > 5'h10 && s_r.cnt <= 5'h13
      |=> s_r.adj == ADJ_LONG;
  endproperty
  a_fm_long: assert property (p_fm_long) else $error("FM late edge not lengthened"); // R15

  property p_nrzi_levels;
    !s_r.fm && s_r.cnt == `DPLL_SEARCH_CNT |-> rxClk && txClk;
  endproperty
  a_nrzi_levels: assert property (p_nrzi_levels) else $error("NRZI rest levels not High"); // R12

  property p_fm_levels;
    s_r.fm && s_r.cnt == `DPLL_SEARCH_CNT |-> !rxClk && !txClk;
  endproperty
  a_fm_levels: assert property (p_fm_levels) else $error("FM rest levels not Low"); // R17

  property p_tx_lag;
    s_r.st == ST_RUN && s_r.fm && s_r.adj == ADJ_NONE && !cmdHit && $rose(rxClk) ##1 !cmdHit [*4]
      |-> $rose(txClk);
  endproperty
  a_tx_lag: assert property (p_tx_lag) else $error("transmit clock lag wrong"); // R13

  property p_one_miss;
    s_r.st == ST_RUN && s_r.fm && s_r.cnt == `DPLL_FM_WIN_HI && !s_r.seen && !edgePulse && !cmdHit
      |=> oneMissing;
  endproperty
  a_one_miss: assert property (p_one_miss) else $error("missed edge not flagged"); // R19

  property p_two_miss_hunt;
    s_r.st == ST_RUN && s_r.goHunt && s_r.cnt == `DPLL_DECIDE_CNT && !cmdHit
      |-> !rxClk && !txClk ##1 s_r.st == ST_HUNT && twoMissing;
  endproperty
  a_two_miss_hunt: assert property (p_two_miss_hunt) else $error("search not entered at count 2"); // R20

  property p_flag_hold;
    oneMissing && !cmdHit |=> oneMissing;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("missing flag dropped"); // R21

  property p_flag_zero;
    !s_r.fm || s_r.st == ST_OFF |-> !oneMissing && !twoMissing;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flag set in NRZI or disabled"); // R22

  property p_lock_c;
    s_r.st == ST_HUNT ##1 s_r.st == ST_RUN;
  endproperty
  c_lock: cover property (p_lock_c);

  property p_long_c;
    s_r.adj == ADJ_LONG && s_r.cnt == `DPLL_ADJ_CNT ##1 s_r.cnt == `DPLL_ADJ_CNT;
  endproperty
  c_long: cover property (p_long_c);

  property p_fm_long_c;
    s_r.fm && s_r.adj == ADJ_LONG && s_r.cnt == `DPLL_ADJ_CNT;
  endproperty
  c_fm_long: cover property (p_fm_long_c);

  property p_two_c;
    s_r.st == ST_RUN && twoMissing ##[1:40] s_r.st == ST_HUNT;
  endproperty
  c_two: cover property (p_two_c);

endmodule

//--- hw/dpll_consts.svh
// Constants for the clock recovery loop: command codes, counts and windows
// Notes on behaviour
// R1: Begin-hunt command enables the loop, releasing the frozen counter and the edge detector.
// R2: Begin-hunt while already enabled forces the loop back into search.
// R3: Search holds the count until a data edge; that edge starts the output.
// R4: With no further edges the output free runs at source clock over 32.
// R5: Each later edge lengthens or shortens one counting cycle by one count.
// R6: Software changes the NRZI/FM mode only while the loop is disabled.
// R7: NRZI needs a x32 source; both outputs equal, sampling mid cell.
// R8: NRZI edges late in count 15 or early in 16 cause no correction.
// R9: NRZI edges in counts 16-31 lengthen, in 0-15 shorten the next cycle.
// R10: NRZI cycle without an edge leaves the next cycle unadjusted.
// R11: Corrections delete or repeat count 5, so only the Low time changes; in FM the receive clock is High at count 5, so its High time changes.
// R12: NRZI search rests at count 16 with both outputs High.
// R13: FM needs a x16 source; transmit lags receive by 90 degrees.
// R14: FM counter still runs 0 to 31, one cycle spanning two bit cells.
// R15: FM edges between mid 16 and mid 19 lengthen the next cycle.
// R16: FM edges from mid 19 to mid 12 of next cycle are ignored.
// R17: FM search, including disabled, rests at count 16 with both outputs Low.
// R18: While disabled, toggling FM and NRZI mode toggles both clock outputs.
// R19: FM cycle without edge in mid 12 to mid 19 latches the one-missing flag.
// R20: Two missed cycles latch the two-missing flag; search entered at count 2.
// R21: Missing flags stay until clear command, disable or begin-hunt.
// R22: In NRZI mode or while disabled both missing flags are held at zero.
// R23: Reset disables the loop, selects the clock pin source and NRZI mode.
// R24: Seven loop commands sit in bits 7 to 5 of the control byte.
`ifndef DPLL_CONSTS_SVH
`define DPLL_CONSTS_SVH

`define DPLL_CMD_MSB      7
`define DPLL_CMD_LSB      5
`define DPLL_CMD_NULL     3'h0
`define DPLL_CMD_HUNT     3'h1
`define DPLL_CMD_CLRMISS  3'h2
`define DPLL_CMD_DISABLE  3'h3
`define DPLL_CMD_SRC_BRG  3'h4
`define DPLL_CMD_SRC_PIN  3'h5
`define DPLL_CMD_FM       3'h6
`define DPLL_CMD_NRZI     3'h7

`define DPLL_CNT_W        5
`define DPLL_SEARCH_CNT   5'h10
`define DPLL_ADJ_CNT      5'h05
`define DPLL_PRE_ADJ_CNT  5'h04
`define DPLL_DECIDE_CNT   5'h02
`define DPLL_NRZI_OK_LO   5'h0f
`define DPLL_NRZI_OK_HI   5'h10
`define DPLL_FM_WIN_LO    5'h0d
`define DPLL_FM_WIN_HI    5'h13
`define DPLL_FM_RX_PHASE  5'h04

`endif

//--- hw/dpll_pkg.sv
// Types shared by the clock recovery loop modules
package dpll_pkg;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_HUNT = 3'b010,
    ST_RUN  = 3'b100
  } loop_state_t;

  typedef enum logic [1:0] {
    ADJ_NONE   = 2'b00,
    ADJ_LONG   = 2'b01,
    ADJ_SHORT  = 2'b10,
    ADJ_IGNORE = 2'b11
  } adj_t;

  typedef struct packed {
    loop_state_t st;
    logic [4:0]  cnt;
    adj_t        adj;
    logic        seen;
    logic        missPrev;
    logic        goHunt;
    logic        fm;
    logic        srcBrg;
    logic        oneMiss;
    logic        twoMiss;
    logic        rxClk;
    logic        txClk;
  } dpll_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pulse;
  } edge_state_t;

endpackage

//--- hw/dpll_edge_detect.sv
// Receive data synchroniser and transition detector
`include "dpll_consts.svh"

module dpll_edge_detect (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic rxData,
  input  wire logic armed,
  output logic      edgePulse
);
  import dpll_pkg::*;

  edge_state_t s_r;
  edge_state_t s_nxt;

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.s1    = rxData;
    s_nxt.s2    = s_r.s1;
    s_nxt.prev  = s_r.s2;
    // R1 detector gated by enable
    s_nxt.pulse = armed & (s_r.s2 ^ s_r.prev);
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign edgePulse = s_r.pulse;

endmodule

//--- testbench/serial_line_model.sv
// Remote sender model driving the received serial data line
module serial_line_model #(
  parameter int CELL_LEN = 16
) (
  input  wire logic mclk,
  input  wire logic run,
  output logic      rxData
);
  timeunit 1ns;
  timeprecision 1ps;

  int phase;

  initial begin
    rxData = 1'b0;
    phase = 0;
  end

  // Manual transition, used for single placed edges
  task automatic flip();
    rxData = ~rxData;
  endtask

  // sixteen clocks a cell
  // Only bit-boundary transitions, as an idle biphase sender gives
  always @(negedge mclk) begin
    if (run) begin
      if (phase == CELL_LEN - 1) begin
        rxData <= ~rxData;
        phase <= 0;
      end else begin
        phase <= phase + 1;
      end
    end else begin
      phase <= 0;
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the clock recovery loop
`include "dpll_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0] cmd;
    logic [5:0] want;
  } row_t;

  logic       mclk;
  logic       rst;
  logic       rxData;
  logic       run;
  logic       ctrlWrite;
  logic [7:0] ctrlByte;
  logic       rxClk;
  logic       txClk;
  logic       srcBrg;
  logic       fmMode;
  logic       enabled;
  logic       searching;
  logic       oneMissing;
  logic       twoMissing;
  int         fail_count;
  int         checks_done;
  int         cycles;
  int         p;
  int         n;
  row_t       rows [8];
  logic [2:0] clrCmd [3];

  dpll_clock_recovery i_dut (
    .mclk       (mclk),
    .rst        (rst),
    .rxData     (rxData),
    .ctrlByte   (ctrlByte),
    .ctrlWrite  (ctrlWrite),
    .rxClk      (rxClk),
    .txClk      (txClk),
    .srcBrg     (srcBrg),
    .fmMode     (fmMode),
    .enabled    (enabled),
    .searching  (searching),
    .oneMissing (oneMissing),
    .twoMissing (twoMissing)
  );

  serial_line_model i_line (
    .mclk   (mclk),
    .run    (run),
    .rxData (rxData)
  );

  // --------------------------------
  // Clock and timeout
  // --------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One command, then one idle cycle so strobes never repeat in a step
  task automatic sendCmd(input logic [2:0] c);
    ctrlByte = {c, 5'h00};
    ctrlWrite = 1'b1;
    @(negedge mclk);
    ctrlWrite = 1'b0;
    ctrlByte = 8'h00;
    @(negedge mclk);
  endtask

  // Cycles until the next receive clock rise; both outputs match in NRZI
  task automatic waitRise(output int cnt);
    logic last;
    cnt = 0;
    do begin
      last = rxClk;
      @(negedge mclk);
      cnt++;
      if (!fmMode) check(txClk, rxClk);
    end while (!(last === 1'b0 && rxClk === 1'b1) && cnt < 300);
  endtask

  // Period from a rise to the next, with an optional edge placed k cycles in
  task automatic period(input int k, output int cnt);
    repeat (k) @(negedge mclk);
    if (k > 0) i_line.flip();
    waitRise(cnt);
    cnt += k;
  endtask

  task automatic waitOn(input int sel, input logic val);
    int w;
    w = 0;
    while ((sel == 0 ? searching : oneMissing) !== val && w < 400) begin
      @(negedge mclk);
      w++;
    end
    if (w >= 400) begin
      fail_count++;
      $display("BAD t=%0t wait sel=%h", $time, sel);
    end
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    rst = 1'b1;
    run = 1'b0;
    ctrlWrite = 1'b0;
    ctrlByte = 8'h00;
    rows[0] = '{`DPLL_CMD_FM, 6'b100100};
    rows[1] = '{`DPLL_CMD_NRZI, 6'b000111};
    rows[2] = '{`DPLL_CMD_SRC_BRG, 6'b010111};
    rows[3] = '{`DPLL_CMD_SRC_PIN, 6'b000111};
    rows[4] = '{`DPLL_CMD_NULL, 6'b000111};
    rows[5] = '{`DPLL_CMD_CLRMISS, 6'b000111};
    rows[6] = '{`DPLL_CMD_HUNT, 6'b001111};
    rows[7] = '{`DPLL_CMD_DISABLE, 6'b000111};
    clrCmd[0] = `DPLL_CMD_CLRMISS;
    clrCmd[1] = `DPLL_CMD_HUNT;
    clrCmd[2] = `DPLL_CMD_DISABLE;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    check({fmMode, srcBrg, enabled, searching, rxClk, txClk}, 8'h07);
    check({oneMissing, twoMissing}, 8'h00);
    // mode changes below are made only while disabled
    foreach (rows[i]) begin
      sendCmd(rows[i].cmd);
      check({fmMode, srcBrg, enabled, searching, rxClk, txClk}, rows[i].want);
    end
    // NRZI: hunt, lock on a first edge, then placed edges
    sendCmd(`DPLL_CMD_HUNT);
    repeat (100) @(negedge mclk);
    check({searching, rxClk, txClk}, 8'h07);
    i_line.flip();
    waitRise(p);
    check(searching, 1'b0);
    period(0, p);
    check(p, 32);
    period(8, p);
    check(p, 33);
    period(0, p);
    check(p, 32);
    period(24, p);
    check(p, 32);
    period(0, p);
    check(p, 31);
    period(29, p);
    check(p, 32);
    period(0, p);
    check(p, 32);
    sendCmd(`DPLL_CMD_HUNT);
    check({searching, rxClk}, 8'h03);
    sendCmd(`DPLL_CMD_DISABLE);
    // FM: lock, phase of transmit against receive, then loss of edges
    sendCmd(`DPLL_CMD_FM);
    sendCmd(`DPLL_CMD_HUNT);
    check({fmMode, enabled, searching, rxClk, txClk}, 8'h1c);
    foreach (clrCmd[i]) begin
      run = 1'b1;
      waitOn(0, 1'b0);
      waitRise(p);
      waitRise(p);
      check(p, 16);
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (txClk !== 1'b1 && n < 20);
      check(n, 4);
      check({oneMissing, twoMissing}, 8'h00);
      run = 1'b0;
      waitOn(1, 1'b1);
      check({twoMissing, searching}, 8'h00);
      waitOn(0, 1'b1);
      check({oneMissing, twoMissing, rxClk, txClk}, 8'h0c);
      sendCmd(clrCmd[i]);
      check({oneMissing, twoMissing}, 8'h00);
    end
    // FM: lock on one placed edge, then a late edge doubles count 5
    sendCmd(`DPLL_CMD_HUNT);
    i_line.flip();
    waitRise(p);
    period(26, p);
    check(p, 32);
    period(0, p);
    check(p, 16);
    period(0, p);
    check(p, 17);
    complete_run();
  end
endmodule
